// [core/tec_ctrl.v]
// Local design decision: the plain strobed port.
`timescale 1ns/1ps
`include "tec_consts.vh"
// ==========================================
// event, interrupt-enable and debug control of a timer unit
module tec_ctrl (
    input  wire        clock,
    input  wire        reset,
    input  wire        clock_enable,
    input  wire [4:0]  address,
    input  wire [15:0] write_data,
    input  wire        write_strobe,
    input  wire        read_strobe,
    output reg  [15:0] read_data,
    input  wire        soft_reset,
    input  wire        timer_enabled,
    input  wire        write_locked,
    input  wire        debug_halt,
    input  wire        match_capture_0,
    input  wire        match_capture_1,
    input  wire        counter_wrap,
    input  wire        capture_0,
    input  wire        capture_1,
    input  wire        sync_done,
    input  wire        flag_clear_0,
    input  wire        flag_clear_1,
    input  wire        flag_clear_err,
    input  wire        flag_clear_wrap,
    input  wire        flag_clear_sync,
    input  wire        event_in,
    output wire        count_enable,
    output reg         channel_match_event_out_0,
    output reg         channel_match_event_out_1,
    output reg         wrap_event_out,
    output reg         action_retrigger,
    output reg         action_count,
    output reg         action_start,
    output reg         period_then_width_capture,
    output reg         width_then_period_capture,
    output reg         event_input_level,
    output reg  [7:0]  irq_flags,
    output wire        irq_request
);

    reg        keep_running_when_halted;
    reg [15:0] event_control;
    reg [7:0]  irq_enable;
    reg        event_meta;
    reg        event_sync;
    reg        halt_meta;
    reg        halt_sync;
    reg        event_prev;
    reg [7:0]  next_flags;
    reg [2:0]  next_action;
    wire       event_level;
    wire       event_edge;
    wire       event_ok;

    // decode of one register offset strobe
    function hit;
        input [4:0] a;
        input [4:0] off;
        input       strobe;
        begin
            hit = strobe && (a == off);
        end
    endfunction

    // ==========================================
    // pin synchronisers; first stage read only by the second
    always @(posedge clock) begin
        if (reset) begin
            event_meta <= 1'b0;
            event_sync <= 1'b0;
            halt_meta  <= 1'b0;
            halt_sync  <= 1'b0;
        end else if (clock_enable) begin
            event_meta <= event_in;
            event_sync <= event_meta;
            halt_meta  <= debug_halt;
            halt_sync  <= halt_meta;
        end
    end

    // ==========================================
    // debug control; soft reset deliberately not applied
    // survives soft reset
    always @(posedge clock) begin
        if (reset) begin
            keep_running_when_halted <= 1'b0;
        end else if (clock_enable &&
                     hit(address, `TEC_OFF_DEBUG_CONTROL, write_strobe) && !write_locked) begin
            keep_running_when_halted <= write_data[`TEC_BIT_KEEP_RUNNING];
        end
    end

    assign count_enable = keep_running_when_halted || !halt_sync;

    // ==========================================
    // event control, enable-protected
    always @(posedge clock) begin
        if (reset || (clock_enable && soft_reset)) begin
            event_control <= `TEC_RST_EVENT_CONTROL;
        end else if (clock_enable && hit(address, `TEC_OFF_EVENT_CONTROL, write_strobe)
                     && !timer_enabled && !write_locked) begin
            event_control <= write_data & `TEC_MASK_EVENT_CONTROL;
        end
    end

    // ==========================================
    // shared interrupt enable state
    always @(posedge clock) begin
        if (reset || (clock_enable && soft_reset)) begin
            irq_enable <= `TEC_RST_IRQ_EN;
        end else if (clock_enable && !write_locked) begin
            if (hit(address, `TEC_OFF_IRQ_EN_CLEAR, write_strobe)) begin
                irq_enable <= irq_enable & ~(write_data[7:0] & `TEC_MASK_IRQ_EN);
            end
            // write one sets, sync bit included
            if (hit(address, `TEC_OFF_IRQ_EN_SET, write_strobe)) begin
                irq_enable <= irq_enable | (write_data[7:0] & `TEC_MASK_IRQ_EN);
            end
        end
    end

    // ==========================================
    // incoming event: polarity, gate, rising edge
    // optional inversion
    assign event_level = event_sync ^ event_control[`TEC_BIT_EVI_INV];
    assign event_edge  = event_level && !event_prev;
    assign event_ok    = event_control[`TEC_BIT_EVI_EN];

    always @(posedge clock) begin
        if (reset) begin
            event_prev <= 1'b0;
        end else if (clock_enable) begin
            event_prev <= event_level;
        end
    end

    // ==========================================
    // action decode; unnamed codes fall to no action
    always @* begin
        next_action = `TEC_ACT_OFF;
        if (event_ok) begin
            next_action = event_control[2:0];
        end
    end

    // action pulses and capture mode levels
    always @(posedge clock) begin
        if (reset) begin
            action_retrigger          <= 1'b0;
            action_count              <= 1'b0;
            action_start              <= 1'b0;
            period_then_width_capture <= 1'b0;
            width_then_period_capture <= 1'b0;
            event_input_level         <= 1'b0;
        end else if (clock_enable) begin
            action_retrigger <= event_edge && (next_action == `TEC_ACT_RETRIGGER);
            action_count     <= event_edge && (next_action == `TEC_ACT_COUNT);
            action_start     <= event_edge && (next_action == `TEC_ACT_START);
            period_then_width_capture <= (next_action == `TEC_ACT_PERIOD_WIDTH);
            width_then_period_capture <= (next_action == `TEC_ACT_WIDTH_PERIOD);
            // level for the pulse-measurement capture path
            event_input_level <= event_ok && event_level;
        end
    end

    // ==========================================
    // outgoing events, one pulse per source pulse
    always @(posedge clock) begin
        if (reset) begin
            channel_match_event_out_0 <= 1'b0;
            channel_match_event_out_1 <= 1'b0;
            wrap_event_out            <= 1'b0;
        end else if (clock_enable) begin
            channel_match_event_out_0 <= match_capture_0 && event_control[`TEC_BIT_CH0_EVO];
            channel_match_event_out_1 <= match_capture_1 && event_control[`TEC_BIT_CH1_EVO];
            wrap_event_out <= counter_wrap && event_control[`TEC_BIT_WRAP_EVO];
        end
    end

    // ==========================================
    // interrupt flags; a set in the clear cycle wins
    always @* begin
        next_flags = irq_flags;
        if (flag_clear_0)    next_flags[`TEC_BIT_IRQ_CH0]  = 1'b0;
        if (flag_clear_1)    next_flags[`TEC_BIT_IRQ_CH1]  = 1'b0;
        if (flag_clear_err)  next_flags[`TEC_BIT_IRQ_ERR]  = 1'b0;
        if (flag_clear_wrap) next_flags[`TEC_BIT_IRQ_WRAP] = 1'b0;
        if (flag_clear_sync) next_flags[`TEC_BIT_IRQ_SYNC] = 1'b0;
        if (match_capture_0) next_flags[`TEC_BIT_IRQ_CH0]  = 1'b1;
        if (match_capture_1) next_flags[`TEC_BIT_IRQ_CH1]  = 1'b1;
        if (counter_wrap)    next_flags[`TEC_BIT_IRQ_WRAP] = 1'b1;
        if (sync_done)       next_flags[`TEC_BIT_IRQ_SYNC] = 1'b1;
        if ((capture_0 && irq_flags[`TEC_BIT_IRQ_CH0]) ||
            (capture_1 && irq_flags[`TEC_BIT_IRQ_CH1])) begin
            next_flags[`TEC_BIT_IRQ_ERR] = 1'b1;
        end
    end

    always @(posedge clock) begin
        if (reset || (clock_enable && soft_reset)) begin
            irq_flags <= 8'h00;
        end else if (clock_enable) begin
            irq_flags <= next_flags;
        end
    end

    assign irq_request = |(irq_flags & irq_enable);

    // ==========================================
    // register read, data one cycle after strobe
    always @(posedge clock) begin
        if (reset) begin
            read_data <= 16'h0000;
        end else if (clock_enable) begin
            read_data <= 16'h0000;
            if (read_strobe) begin
                case (address)
                    `TEC_OFF_DEBUG_CONTROL: read_data <= {15'h0000, keep_running_when_halted};
                    `TEC_OFF_EVENT_CONTROL: read_data <= event_control;
                    `TEC_OFF_EVENT_CTRL_HI: read_data <= {8'h00, event_control[15:8]};
                    `TEC_OFF_IRQ_EN_CLEAR:  read_data <= {8'h00, irq_enable};
                    `TEC_OFF_IRQ_EN_SET:    read_data <= {8'h00, irq_enable};
                    default:                read_data <= 16'h0000;
                endcase
            end
        end
    end

endmodule

// [shared/tec_consts.vh]
// What this block does
// - debug_control bit 0: 0 freezes counter on debugger halt, 1 keeps running.
// - debug-run bit survives the timer software reset.
// - event_control bits 12,13 enable one event per channel match or capture.
// - event_control bit 8 enables one event per counter overflow or underflow.
// - event_control bit 5 accepts incoming events; when clear they are ignored.
// - event_control bit 4 inverts the incoming event source.
// - action field 2:0: none, retrigger, count, start.
// - action 5 period to register 0, width 1; action 6 swapped.
// - event_control writable only while timer disabled and not write-locked.
// - writing 1 to enable-clear bit clears that enable; 0 leaves it.
// - writing 1 to enable-set bit sets that enable; 0 leaves it.
// - set and clear registers share one enable state, both read it.
// - enable bits 4,5 gate channel 0 and 1 interrupts.
// - enable bit 1 gates the capture-overrun error interrupt.
// - enable bit 0 gates the overflow interrupt.
// - enable bit 3 gates sync-ready; clear-register bit 3 disables it.
// - a source requests an interrupt only when flag and enable both set.
// - error flag sets when capture arrives while its channel flag still set.
`ifndef TEC_CONSTS_VH
`define TEC_CONSTS_VH
// ==========================================
// register offsets
`define TEC_OFF_DEBUG_CONTROL  5'h08
`define TEC_OFF_EVENT_CONTROL  5'h0a
`define TEC_OFF_EVENT_CTRL_HI  5'h0b
`define TEC_OFF_IRQ_EN_CLEAR   5'h0c
`define TEC_OFF_IRQ_EN_SET     5'h0d
// ==========================================
// field positions
`define TEC_BIT_KEEP_RUNNING   0
`define TEC_BIT_WRAP_EVO       8
`define TEC_BIT_CH0_EVO        12
`define TEC_BIT_CH1_EVO        13
`define TEC_BIT_EVI_EN         5
`define TEC_BIT_EVI_INV        4
`define TEC_BIT_IRQ_WRAP       0
`define TEC_BIT_IRQ_ERR        1
`define TEC_BIT_IRQ_SYNC       3
`define TEC_BIT_IRQ_CH0        4
`define TEC_BIT_IRQ_CH1        5
// ==========================================
// reset values and masks
`define TEC_RST_DEBUG          8'h00
`define TEC_RST_EVENT_CONTROL         16'h0000
`define TEC_RST_IRQ_EN         8'h00
`define TEC_MASK_EVENT_CONTROL        16'h3137
`define TEC_MASK_IRQ_EN        8'h3b
// ==========================================
// event actions
`define TEC_ACT_OFF            3'h0
`define TEC_ACT_RETRIGGER      3'h1
`define TEC_ACT_COUNT          3'h2
`define TEC_ACT_START          3'h3
`define TEC_ACT_PERIOD_WIDTH   3'h5
`define TEC_ACT_WIDTH_PERIOD   3'h6
`endif

// [tb/tb.sv]
`timescale 1ns/1ps
`include "tec_consts.vh"
// ==========================================
// bench for the timer control block
module tb;
    reg         clock, reset, we, re, sr, ten, wl, halt;
    reg  [4:0]  addr, fc;
    reg  [15:0] wd;
    reg  [5:0]  src;
    wire [15:0] read_data;
    wire [7:0]  irq_flags;
    wire        event_in, count_enable, irq_request, ptw, wtp, lvl;
    wire [5:0]  outs;
    integer     error_cnt, comparisons, cycles, k;

    tec_ctrl u_tec_ctrl (.clock(clock), .reset(reset), .clock_enable(1'b1), .address(addr),
        .write_data(wd), .write_strobe(we), .read_strobe(re), .read_data(read_data),
        .soft_reset(sr), .timer_enabled(ten), .write_locked(wl), .debug_halt(halt),
        .match_capture_0(src[1]), .match_capture_1(src[2]), .counter_wrap(src[0]),
        .capture_0(src[3]), .capture_1(src[4]), .sync_done(src[5]),
        .flag_clear_0(fc[2]), .flag_clear_1(fc[3]), .flag_clear_err(fc[1]),
        .flag_clear_wrap(fc[0]), .flag_clear_sync(fc[4]), .event_in(event_in),
        .count_enable(count_enable), .channel_match_event_out_0(outs[1]),
        .channel_match_event_out_1(outs[2]), .wrap_event_out(outs[0]),
        .action_retrigger(outs[3]), .action_count(outs[4]), .action_start(outs[5]),
        .period_then_width_capture(ptw), .width_then_period_capture(wtp),
        .event_input_level(lvl), .irq_flags(irq_flags), .irq_request(irq_request));
    tec_evnet u_net (.clock(clock), .pulses(outs), .event_in(event_in));

    task chk(input [15:0] got, input [15:0] exp);
        begin
            comparisons = comparisons + 1;
            if (got !== exp) begin
                error_cnt = error_cnt + 1;
                $display("Error at %0t: got %h expected %h", $time, got, exp);
            end
        end
    endtask
    // bus cycles start just after an edge and leave on an edge
    task wr(input [4:0] a, input [15:0] d);
        begin
            addr <= a; wd <= d; we <= 1'b1;
            @(posedge clock);
            we <= 1'b0;
            @(posedge clock);
        end
    endtask
    task rd(input [4:0] a, input [15:0] exp);
        begin
            addr <= a; re <= 1'b1;
            @(posedge clock);
            re <= 1'b0;
            #1 chk(read_data, exp);
            @(posedge clock);
        end
    endtask
    task pulse(input [5:0] s);
        begin
            src <= s;
            @(posedge clock);
            src <= 6'h00;
            repeat (3) @(posedge clock);
        end
    endtask
    task conclude;
        begin
            if (error_cnt == 0 && comparisons > 0)
                $display("Run complete: PASS");
            else
                $display("Run complete: FAIL");
            $finish;
        end
    endtask
    // a hang is cut short well past the expected run length
    always @(posedge clock) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            error_cnt = error_cnt + 1;
            conclude;
        end
    end
    initial begin
        clock = 1'b0;
        forever #2.5 clock = ~clock;
    end
    initial begin
        {reset, we, re, sr, ten, wl, halt} = 7'h40;
        {addr, fc, wd, src} = 32'h0;
        error_cnt = 0; comparisons = 0; cycles = 0;
        repeat (12) @(posedge clock);
        reset <= 1'b0;
        @(posedge clock);
        // reset values, an unmapped hole, shared enable state
        rd(`TEC_OFF_DEBUG_CONTROL, 16'h0000);
        rd(`TEC_OFF_EVENT_CONTROL, 16'h0000);
        rd(5'h1f, 16'h0000);
        wr(`TEC_OFF_IRQ_EN_SET, 16'h00ff);
        rd(`TEC_OFF_IRQ_EN_CLEAR, 16'h003b);
        wr(`TEC_OFF_IRQ_EN_CLEAR, 16'h0019);
        rd(`TEC_OFF_IRQ_EN_SET, 16'h0022);
        // event control guarded by enable and lock; action 7 left harmless
        wr(`TEC_OFF_EVENT_CONTROL, 16'hffff);
        rd(`TEC_OFF_EVENT_CONTROL, 16'h3137);
        ten <= 1'b1;
        wr(`TEC_OFF_EVENT_CONTROL, 16'h0000);
        {ten, wl} <= 2'b01;
        wr(`TEC_OFF_EVENT_CONTROL, 16'h0000);
        wl <= 1'b0;
        rd(`TEC_OFF_EVENT_CONTROL, 16'h3137);
        // outgoing events on, then off
        pulse(6'h07);
        chk(u_net.cnt[0] + u_net.cnt[1] + u_net.cnt[2], 16'h0003);
        wr(`TEC_OFF_EVENT_CONTROL, 16'h0000);
        pulse(6'h07);
        chk(u_net.cnt[0] + u_net.cnt[1] + u_net.cnt[2], 16'h0003);
        // every action code once
        for (k = 0; k < 8; k = k + 1) begin
            wr(`TEC_OFF_EVENT_CONTROL, 16'h0020 | k);
            u_net.fire;
            chk({ptw, wtp}, (k == 5) ? 16'h0002 : (k == 6) ? 16'h0001 : 16'h0000);
        end
        chk({u_net.cnt[3], u_net.cnt[4], u_net.cnt[5]} == 48'h000100010001, 16'h0001);
        wr(`TEC_OFF_EVENT_CONTROL, 16'h0001);
        u_net.fire;
        chk(u_net.cnt[3], 16'h0001);
        wr(`TEC_OFF_EVENT_CONTROL, 16'h0030);
        repeat (4) @(posedge clock);
        chk(lvl, 16'h0001);
        // debug halt freezes unless told to keep running
        halt <= 1'b1;
        repeat (4) @(posedge clock);
        chk(count_enable, 16'h0000);
        wr(`TEC_OFF_DEBUG_CONTROL, 16'h0001);
        chk(count_enable, 16'h0001);
        halt <= 1'b0;
        sr <= 1'b1;
        @(posedge clock);
        sr <= 1'b0;
        @(posedge clock);
        rd(`TEC_OFF_DEBUG_CONTROL, 16'h0001);
        rd(`TEC_OFF_EVENT_CONTROL, 16'h0000);
        // flags, enables and the request line
        wr(`TEC_OFF_IRQ_EN_SET, 16'h003b);
        pulse(6'h01);
        chk({irq_request, irq_flags}, 16'h0101);
        wr(`TEC_OFF_IRQ_EN_CLEAR, 16'h0001);
        chk({irq_request, irq_flags}, 16'h0001);
        fc <= 5'h01;
        @(posedge clock);
        fc <= 5'h00;
        pulse(6'h02);
        pulse(6'h08);
        chk({irq_request, irq_flags}, 16'h0112);
        conclude;
    end
endmodule

// [tb/tec_ctrl_props.sv]
`timescale 1ns/1ps
// ==========================================
// port-level checks of the timer control block
module tec_ctrl_props (
    input wire        clock,
    input wire        reset,
    input wire        soft_reset,
    input wire        read_strobe,
    input wire [15:0] read_data,
    input wire        debug_halt,
    input wire        count_enable,
    input wire        match_capture_0,
    input wire        counter_wrap,
    input wire        capture_0,
    input wire        channel_match_event_out_0,
    input wire        wrap_event_out,
    input wire        action_retrigger,
    input wire        action_count,
    input wire        action_start,
    input wire        period_then_width_capture,
    input wire        width_then_period_capture,
    input wire [7:0]  irq_flags,
    input wire        irq_request
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (reset);
    // any action pulse at all
    wire any_act = action_retrigger | action_count | action_start;

    property p_halt_freeze; $fell(count_enable) |-> $past(debug_halt, 2); endproperty
    a_halt_freeze: assert property (p_halt_freeze) else $error("freeze without halt");
    property p_ch0_evo; channel_match_event_out_0 |-> $past(match_capture_0); endproperty
    a_ch0_evo: assert property (p_ch0_evo) else $error("channel event without match");
    property p_wrap_evo; wrap_event_out |-> $past(counter_wrap); endproperty
    a_wrap_evo: assert property (p_wrap_evo) else $error("wrap event without wrap");
    property p_act_one; $onehot0({action_retrigger, action_count, action_start}); endproperty
    a_act_one: assert property (p_act_one) else $error("two actions at once");
    property p_act_pulse; any_act |=> !any_act; endproperty
    a_act_pulse: assert property (p_act_pulse) else $error("action pulse too long");
    property p_cap_mode; !(period_then_width_capture && width_then_period_capture); endproperty
    a_cap_mode: assert property (p_cap_mode) else $error("both capture modes");
    property p_irq; irq_request |-> irq_flags != 8'h00; endproperty
    a_irq: assert property (p_irq) else $error("request with no flag");
    property p_overrun; capture_0 && irq_flags[4] && !soft_reset |=> irq_flags[1]; endproperty
    a_overrun: assert property (p_overrun) else $error("overrun not flagged");
    property p_rd_idle; !$past(read_strobe) |-> read_data == 16'h0000; endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("read data outside slot");
endmodule

bind tec_ctrl tec_ctrl_props u_tec_ctrl_props (
    .clock, .reset, .soft_reset, .read_strobe, .read_data, .debug_halt, .count_enable,
    .match_capture_0, .counter_wrap, .capture_0, .channel_match_event_out_0,
    .wrap_event_out, .action_retrigger, .action_count, .action_start,
    .period_then_width_capture, .width_then_period_capture, .irq_flags, .irq_request
);

// [tb/tec_evnet.sv]
`timescale 1ns/1ps
// ==========================================
// event network stand-in: raises the event line, counts pulses
module tec_evnet (
    input  wire       clock,
    input  wire [5:0] pulses,
    output reg        event_in
);
    reg [15:0] cnt [0:5];
    integer    i;
    initial begin
        event_in = 1'b0;
        for (i = 0; i < 6; i = i + 1)
            cnt[i] = 16'h0000;
    end
    // one count per cycle a pulse stands
    always @(posedge clock) begin
        for (i = 0; i < 6; i = i + 1)
            if (pulses[i])
                cnt[i] <= cnt[i] + 16'h0001;
    end
    // held past the two-stage sync, then dropped so the next rise is clean
    task fire;
        begin
            event_in <= 1'b1;
            repeat (4) @(posedge clock);
            event_in <= 1'b0;
            repeat (5) @(posedge clock);
        end
    endtask
endmodule
